// ### plo_field.sv
// field model: contact and sync inputs, relay 0 closure counter
// assumes the bench gives the wanted input states h..a
`timescale 1ns/1ps
`default_nettype none
module plo_field (
    // clock
    input wire logic clk_sys,
    // wanted states h..a
    input wire logic [7:0] fieldSet,
    // device pins
    output logic [3:0] contactIn,
    output logic [3:0] syncIn,
    input wire logic [1:0] logicOut,
    // closures of relay 0
    output logic [7:0] closeCnt0
);
    // ====================
    // contacts and relay
    logic relayWas;
    initial begin
        {syncIn, contactIn} = 8'h00;
        relayWas = 1'b0;
        closeCnt0 = 8'h00;
    end
    always @(posedge clk_sys) begin
        {syncIn, contactIn} <= fieldSet;
        relayWas <= logicOut[0];
        if (logicOut[0] && !relayWas) begin
            closeCnt0 <= closeCnt0 + 8'h01;
        end
    end
endmodule : plo_field
`default_nettype wire

// ### plo_pkg.sv
// package for the programmable logic output block
// assumes a 10 MHz system clock and a 10 ms timing tick
package plo_pkg;
    localparam int CLK_HZ = 10000000;
    localparam int TICK_MS = 10;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int EQ_LEN = 15;
    localparam int NUM_OUT = 2;
    localparam int NUM_RECL = 4;
    localparam logic [14:0] DLY_MIN = 15'h0001;
    localparam logic [14:0] DLY_MAX = 15'h61A8;
    localparam logic [14:0] DLY_RST = 15'h0001;
    // symbol codes: 0..15 = A,a,B,b..H,h (bit0 = active low), 16 plus, 17 equals
    localparam logic [4:0] SYM_PLUS = 5'h10;
    localparam logic [4:0] SYM_EQ = 5'h11;
    localparam logic [4:0] SYM_LAST = 5'h11;
    localparam logic [4:0] SYM_RST = 5'h11;
    localparam int ADDR_CTRL = 32'h00;
    localparam int ADDR_EDIT = 32'h04;
    localparam int ADDR_PKUP0 = 32'h08;
    localparam int ADDR_DROP0 = 32'h0C;
    localparam int ADDR_PKUP1 = 32'h10;
    localparam int ADDR_DROP1 = 32'h14;
    localparam int ADDR_STAT = 32'h18;
    localparam int ADDR_SUPV = 32'h1C;
    localparam int ADDR_EQ0 = 32'h20;
    localparam int ADDR_EQ1 = 32'h60;
    // ctrl fields
    localparam int CTRL_GEN = 0;
    localparam int CTRL_OEN0 = 1;
    localparam int CTRL_OEN1 = 2;
    localparam int CTRL_EXTSRC = 3;
    // edit command fields
    localparam int EDIT_OUT = 0;
    localparam int EDIT_START = 1;
    localparam int EDIT_RAISE = 2;
    localparam int EDIT_LOWER = 3;
    localparam int EDIT_ENTER = 4;
    typedef enum logic [1:0] {PLO_IDLE, PLO_PKUP, PLO_ON, PLO_DROP} plo_state_e;
endpackage : plo_pkg

// ### plo_top.sv
// programmable logic outputs with apb settings and equation editor
// assumes contact and sync inputs are asynchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module plo_top
    import plo_pkg::*;
#(parameter int TICK_DIV = TICK_CYC)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // contact inputs a to d
    input wire logic [3:0] contactIn,
    // sync check results: hot line dead bus, hot bus dead line, sync, external sync
    input wire logic [3:0] syncIn,
    // relay contacts
    output logic [1:0] logicOut,
    // per-reclosure settings [r*3 +: 3] = hot line dead bus, hot bus dead line, sync
    input wire logic [11:0] reclSupvSet,
    output logic [11:0] reclSupvEff
);
    // ==========================================================
    // reset release and input synchronisers
    logic rstSync1_r, rstSync2_r;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rstSync1_r <= 1'b0;
            rstSync2_r <= 1'b0;
        end else begin
            rstSync1_r <= 1'b1;
            rstSync2_r <= rstSync1_r;
        end
    end
    logic rstN;
    assign rstN = rstSync2_r;

    logic [7:0] in1_r, in2_r, in3_r, varIn_r;
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            in1_r <= 8'h00;
            in2_r <= 8'h00;
            in3_r <= 8'h00;
            varIn_r <= 8'h00;
        end else begin
            in1_r <= {syncIn, contactIn};
            in2_r <= in1_r;
            in3_r <= in2_r;
            for (int i = 0; i < 8; i++) begin
                if (in2_r[i] == in3_r[i]) begin
                    varIn_r[i] <= in3_r[i];
                end
            end
        end
    end

    // ==========================================================
    // tick divider
    logic [19:0] divCnt_r;
    logic tick;
    assign tick = (divCnt_r == 20'(TICK_DIV - 1));
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            divCnt_r <= 20'h00000;
        end else if (tick) begin
            divCnt_r <= 20'h00000;
        end else begin
            divCnt_r <= divCnt_r + 20'h00001;
        end
    end

    // ==========================================================
    // settings and status registers
    logic ctrlGen_r, extSrc_r;
    logic [1:0] outEn_r;
    logic [14:0] pkup_r [NUM_OUT];
    logic [14:0] drop_r [NUM_OUT];
    logic [4:0] eqMem_r [NUM_OUT][EQ_LEN];
    logic [4:0] edBuf_r [EQ_LEN];
    logic [3:0] edPos_r;
    logic edOut_r, edAct_r, updated_r;
    logic [4:0] edSym_r;

    logic wrEn, rdEn;
    assign wrEn = psel && penable && pwrite;
    assign rdEn = psel && penable && !pwrite;
    assign pready = 1'b1;

    function automatic logic [14:0] clampDly(input logic [31:0] v);
        if (v[14:0] < DLY_MIN || v[31:15] != 17'h00000) begin
            clampDly = (v[31:15] != 17'h00000) ? DLY_MAX : DLY_MIN;
        end else if (v[14:0] > DLY_MAX) begin
            clampDly = DLY_MAX;
        end else begin
            clampDly = v[14:0];
        end
    endfunction : clampDly

    logic mapped;
    always_comb begin
        mapped = (paddr < 8'(ADDR_EQ0)) || (paddr < 8'(ADDR_EQ1 + 4 * EQ_LEN) && !pwrite);
    end
    assign pslverr = psel && penable && !mapped;

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            ctrlGen_r <= 1'b0;
            outEn_r <= 2'h0;
            extSrc_r <= 1'b0;
            for (int o = 0; o < NUM_OUT; o++) begin
                pkup_r[o] <= DLY_RST;
                drop_r[o] <= DLY_RST;
            end
        end else if (wrEn) begin
            if (paddr == 8'(ADDR_CTRL)) begin
                ctrlGen_r <= pwdata[CTRL_GEN];
                outEn_r <= {pwdata[CTRL_OEN1], pwdata[CTRL_OEN0]};
                extSrc_r <= pwdata[CTRL_EXTSRC];
            end else if (paddr == 8'(ADDR_PKUP0)) begin
                pkup_r[0] <= clampDly(pwdata);
            end else if (paddr == 8'(ADDR_DROP0)) begin
                drop_r[0] <= clampDly(pwdata);
            end else if (paddr == 8'(ADDR_PKUP1)) begin
                pkup_r[1] <= clampDly(pwdata);
            end else if (paddr == 8'(ADDR_DROP1)) begin
                drop_r[1] <= clampDly(pwdata);
            end
        end
    end

    // ==========================================================
    // equation editor
    logic edCmd;
    assign edCmd = wrEn && (paddr == 8'(ADDR_EDIT));
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            edAct_r <= 1'b0;
            edOut_r <= 1'b0;
            edPos_r <= 4'h0;
            edSym_r <= SYM_RST;
            updated_r <= 1'b0;
            for (int o = 0; o < NUM_OUT; o++) begin
                for (int p = 0; p < EQ_LEN; p++) begin
                    eqMem_r[o][p] <= SYM_EQ;
                end
            end
            for (int p = 0; p < EQ_LEN; p++) begin
                edBuf_r[p] <= SYM_EQ;
            end
        end else begin
            if (wrEn && paddr == 8'(ADDR_STAT) && pwdata[0]) begin
                updated_r <= 1'b0;
            end
            if (!ctrlGen_r) begin
                edAct_r <= 1'b0;
            end else if (edCmd && pwdata[EDIT_START]) begin
                edAct_r <= 1'b1;
                edOut_r <= pwdata[EDIT_OUT];
                edPos_r <= 4'h0;
                edSym_r <= eqMem_r[pwdata[EDIT_OUT]][0];
                edBuf_r <= eqMem_r[pwdata[EDIT_OUT]];
            end else if (edCmd && edAct_r) begin
                if (pwdata[EDIT_RAISE]) begin
                    edSym_r <= (edSym_r == SYM_LAST) ? 5'h00 : edSym_r + 5'h01;
                end else if (pwdata[EDIT_LOWER]) begin
                    edSym_r <= (edSym_r == 5'h00) ? SYM_LAST : edSym_r - 5'h01;
                end else if (pwdata[EDIT_ENTER]) begin
                    edBuf_r[edPos_r] <= edSym_r;
                    if (edSym_r == SYM_EQ || edPos_r == 4'(EQ_LEN - 1)) begin
                        for (int p = 0; p < EQ_LEN; p++) begin
                            eqMem_r[edOut_r][p] <= (p == int'(edPos_r)) ? SYM_EQ : edBuf_r[p];
                        end
                        updated_r <= 1'b1;
                        edAct_r <= 1'b0;
                    end else begin
                        edPos_r <= edPos_r + 4'h1;
                        edSym_r <= edBuf_r[edPos_r + 4'h1];
                    end
                end
            end
        end
    end

    // ==========================================================
    // sum-of-products evaluation
    function automatic logic evalEq(input logic [4:0] eq [EQ_LEN], input logic [7:0] v);
        logic res, term, done, lit;
        res = 1'b0;
        term = 1'b1;
        done = 1'b0;
        lit = 1'b0;
        for (int p = 0; p < EQ_LEN; p++) begin
            if (!done) begin
                if (eq[p] == SYM_PLUS || eq[p] == SYM_EQ) begin
                    res = res | (term & lit);
                    term = 1'b1;
                    lit = 1'b0;
                    done = (eq[p] == SYM_EQ);
                end else begin
                    term = term & (v[eq[p][3:1]] ^ eq[p][0]);
                    lit = 1'b1;
                end
            end
        end
        evalEq = res;
    endfunction : evalEq

    // ==========================================================
    // pick-up and drop-out timing per output
    plo_state_e st_r [NUM_OUT];
    logic [14:0] tmr_r [NUM_OUT];
    logic [1:0] eqTrue;
    always_comb begin
        for (int o = 0; o < NUM_OUT; o++) begin
            eqTrue[o] = evalEq(eqMem_r[o], varIn_r) && ctrlGen_r && outEn_r[o];
        end
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            for (int o = 0; o < NUM_OUT; o++) begin
                st_r[o] <= PLO_IDLE;
                tmr_r[o] <= 15'h0000;
            end
        end else begin
            for (int o = 0; o < NUM_OUT; o++) begin
                if (!ctrlGen_r || !outEn_r[o]) begin
                    st_r[o] <= PLO_IDLE;
                end else begin
                    case (st_r[o])
                        PLO_IDLE: begin
                            if (eqTrue[o]) begin
                                st_r[o] <= PLO_PKUP;
                                tmr_r[o] <= 15'h0000;
                            end
                        end
                        PLO_PKUP: begin
                            if (!eqTrue[o]) begin
                                st_r[o] <= PLO_IDLE;
                            end else if (tick) begin
                                if (tmr_r[o] >= pkup_r[o]) begin
                                    st_r[o] <= PLO_ON;
                                end
                                tmr_r[o] <= tmr_r[o] + 15'h0001;
                            end
                        end
                        PLO_ON: begin
                            if (!eqTrue[o]) begin
                                st_r[o] <= PLO_DROP;
                                tmr_r[o] <= 15'h0000;
                            end
                        end
                        default: begin
                            if (eqTrue[o]) begin
                                st_r[o] <= PLO_ON;
                            end else if (tick) begin
                                if (tmr_r[o] >= drop_r[o]) begin
                                    st_r[o] <= PLO_IDLE;
                                end
                                tmr_r[o] <= tmr_r[o] + 15'h0001;
                            end
                        end
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            logicOut <= 2'h0;
        end else begin
            for (int o = 0; o < NUM_OUT; o++) begin
                logicOut[o] <= (st_r[o] == PLO_ON || st_r[o] == PLO_DROP) && ctrlGen_r && outEn_r[o];
            end
        end
    end

    // ==========================================================
    // external switch supervision enables
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            reclSupvEff <= 12'h000;
        end else begin
            for (int r = 0; r < NUM_RECL; r++) begin
                reclSupvEff[r*3 +: 3] <= extSrc_r ? (reclSupvSet[r*3 +: 3] & varIn_r[2:0])
                                                  : reclSupvSet[r*3 +: 3];
            end
        end
    end

    // ==========================================================
    // read mux
    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= 32'h00000000;
            if (paddr == 8'(ADDR_CTRL)) begin
                prdata <= {28'h0000000, extSrc_r, outEn_r, ctrlGen_r};
            end else if (paddr == 8'(ADDR_EDIT)) begin
                prdata <= {18'h00000, edSym_r, edPos_r, 3'h0, edAct_r, edOut_r};
            end else if (paddr == 8'(ADDR_PKUP0)) begin
                prdata <= {17'h00000, pkup_r[0]};
            end else if (paddr == 8'(ADDR_DROP0)) begin
                prdata <= {17'h00000, drop_r[0]};
            end else if (paddr == 8'(ADDR_PKUP1)) begin
                prdata <= {17'h00000, pkup_r[1]};
            end else if (paddr == 8'(ADDR_DROP1)) begin
                prdata <= {17'h00000, drop_r[1]};
            end else if (paddr == 8'(ADDR_STAT)) begin
                prdata <= {21'h000000, varIn_r, logicOut, updated_r};
            end else if (paddr == 8'(ADDR_SUPV)) begin
                prdata <= {20'h00000, reclSupvEff};
            end else if (paddr >= 8'(ADDR_EQ0) && paddr < 8'(ADDR_EQ0 + 4 * EQ_LEN)) begin
                prdata <= {27'h0000000, eqMem_r[0][4'((paddr - 8'(ADDR_EQ0)) >> 2)]};
            end else if (paddr >= 8'(ADDR_EQ1) && paddr < 8'(ADDR_EQ1 + 4 * EQ_LEN)) begin
                prdata <= {27'h0000000, eqMem_r[1][4'((paddr - 8'(ADDR_EQ1)) >> 2)]};
            end
        end
    end
    logic unusedRd;
    assign unusedRd = rdEn;
endmodule : plo_top
`default_nettype wire

// ### plo_top_sva.sv
// checker for the programmable logic outputs, bound to plo_top
// assumes the two-cycle apb walk and registered field outputs
`timescale 1ns/1ps
`default_nettype none
module plo_top_sva
    import plo_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // field side
    input wire logic [3:0] contactIn,
    input wire logic [1:0] logicOut,
    input wire logic [11:0] reclSupvSet,
    input wire logic [11:0] reclSupvEff
);
    // ====================
    // shadow of control and input settling count
    logic [3:0] ctrlSh_r;
    logic [3:0] stCnt_r;
    logic [16:0] stKey_r;
    logic [16:0] stKey;
    logic [11:0] effExp;
    assign stKey = {ctrlSh_r[3], contactIn, reclSupvSet};
    assign effExp = reclSupvSet & {4{contactIn[2:0]}};
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ctrlSh_r <= 4'h0;
        end else if (psel && penable && pwrite && paddr == 8'h00) begin
            ctrlSh_r <= pwdata[3:0];
        end
    end
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            stKey_r <= 17'h00000;
            stCnt_r <= 4'h0;
        end else begin
            stKey_r <= stKey;
            stCnt_r <= (stKey != stKey_r) ? 4'h0 : (stCnt_r == 4'hC) ? 4'hC : stCnt_r + 4'h1;
        end
    end
    // ====================
    // assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    a_ready_high: assert property (psel |-> pready) else $error("ready low");
    a_err_unmapped: assert property (psel && penable && paddr >= 8'h9C |-> pslverr)
        else $error("no error on unmapped access");
    a_err_write_ro: assert property (psel && penable && pwrite && paddr > 8'h1F |-> pslverr)
        else $error("no error on read-only write");
    a_err_mapped: assert property (psel && penable && !pwrite && paddr < 8'h9C |-> !pslverr)
        else $error("error on mapped read");
    a_glob_off_quiet: assert property (!ctrlSh_r[0] && $past(!ctrlSh_r[0]) &&
        $past(!ctrlSh_r[0], 2) |-> logicOut == 2'h0) else $error("output on while disabled");
    a_out0_off: assert property (!ctrlSh_r[1] [*3] |=> !logicOut[0])
        else $error("output 0 on while its enable off");
    a_out1_off: assert property (!ctrlSh_r[2] [*3] |=> !logicOut[1])
        else $error("output 1 on while its enable off");
    a_supv_ext: assert property (stCnt_r == 4'hC && stKey == stKey_r && ctrlSh_r[3]
        |-> reclSupvEff == effExp) else $error("external enables not applied");
    a_supv_plain: assert property (stCnt_r == 4'hC && stKey == stKey_r && !ctrlSh_r[3]
        |-> reclSupvEff == reclSupvSet) else $error("settings not passed through");
endmodule : plo_top_sva
bind plo_top plo_top_sva plo_top_sva_inst (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .contactIn(contactIn), .logicOut(logicOut),
    .reclSupvSet(reclSupvSet), .reclSupvEff(reclSupvEff));
`default_nettype wire

// ### testbench.sv
// testbench for the programmable logic outputs
// assumes plo_top, plo_field and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import plo_pkg::*;
    // ====================
    // signals and instances
    logic clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr, fieldSet, closeCnt0;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] contactIn, syncIn;
    logic [1:0] logicOut;
    logic [11:0] reclSupvSet, reclSupvEff;
    int errorCnt, cmpCount;
    // short tick keeps the timing runs brief
    localparam int TB_TICK = 100;
    plo_top #(.TICK_DIV(TB_TICK)) plo_top_inst (.clk_sys(clk_sys), .rst_b(rst_b),
        .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .contactIn(contactIn), .syncIn(syncIn), .logicOut(logicOut),
        .reclSupvSet(reclSupvSet), .reclSupvEff(reclSupvEff));
    plo_field plo_field_inst (.clk_sys(clk_sys), .fieldSet(fieldSet), .contactIn(contactIn),
        .syncIn(syncIn), .logicOut(logicOut), .closeCnt0(closeCnt0));
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // ====================
    // shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errorCnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic testDone();
        $display("errors=%0d compares=%0d", errorCnt, cmpCount);
        if (errorCnt == 0 && cmpCount > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : testDone
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic waitOut(input int i, input logic v);
        int n;
        n = 0;
        while (logicOut[i] !== v && n < 400) begin
            @(posedge clk_sys);
            n++;
        end
    endtask : waitOut
    task automatic editEq(input logic [31:0] o, input logic [4:0] s0);
        logic [4:0] tgt;
        apb(1'b1, 8'h04, 32'h2 | o);
        for (int p = 0; p < 2; p++) begin
            tgt = (p == 0) ? s0 : SYM_EQ;
            for (int n = 0; n < 20; n++) begin
                apb(1'b0, 8'h04, 32'h0);
                if (rd[13:9] == tgt) break;
                apb(1'b1, 8'h04, ((rd[13:9] < tgt) ? 32'h4 : 32'h8) | o);
            end
            apb(1'b1, 8'h04, 32'h10 | o);
        end
    endtask : editEq
    // ====================
    // scenarios
    task automatic tRegs();
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 8'h0C, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, 8'h14, 32'h7530);
        apb(1'b0, 8'h14, 32'h0);
        chk(rd, 32'h61A8);
        apb(1'b0, 8'hA0, 32'h0);
        chk({rd[30:0], er}, 32'h1);
    endtask : tRegs
    task automatic tEdit();
        apb(1'b1, 8'h04, 32'h2);
        apb(1'b0, 8'h04, 32'h0);
        chk(32'(rd[1]), 32'h0);
        apb(1'b1, 8'h00, 32'h1);
        editEq(32'h0, 5'h00);
        editEq(32'h1, 5'h03);
        apb(1'b0, 8'h18, 32'h0);
        chk(32'(rd[0]), 32'h1);
        apb(1'b0, 8'h24, 32'h0);
        chk(32'(rd[4:0]), 32'(SYM_EQ));
        apb(1'b0, 8'h60, 32'h0);
        chk(32'(rd[4:0]), 32'h3);
        apb(1'b1, 8'h18, 32'h1);
        apb(1'b0, 8'h18, 32'h0);
        chk(32'(rd[0]), 32'h0);
        apb(1'b1, 8'h04, 32'h2);
        apb(1'b1, 8'h04, 32'h4);
        apb(1'b0, 8'h04, 32'h0);
        chk(32'(rd[13:9]), 32'h1);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b0, 8'h04, 32'h0);
        chk(32'(rd[1]), 32'h0);
    endtask : tEdit
    task automatic tSupv();
        reclSupvSet <= 12'hA5B;
        apb(1'b1, 8'h00, 32'h9);
        for (int k = 0; k < 8; k++) begin
            fieldSet <= 8'hA0 | 8'(k);
            repeat (12) @(posedge clk_sys);
            chk(32'(reclSupvEff), 32'(12'hA5B & {4{k[2:0]}}));
        end
        apb(1'b0, 8'h18, 32'h0);
        chk(32'(rd[10:3]), 32'hA7);
        apb(1'b1, 8'h00, 32'h1);
        fieldSet <= 8'h00;
        repeat (12) @(posedge clk_sys);
        chk(32'(reclSupvEff), 32'hA5B);
    endtask : tSupv
    task automatic tTiming();
        apb(1'b1, 8'h08, 32'h2);
        apb(1'b1, 8'h0C, 32'h2);
        apb(1'b1, 8'h00, 32'h3);
        fieldSet <= 8'h01;
        repeat (200) @(posedge clk_sys);
        chk(32'(logicOut), 32'h0);
        waitOut(0, 1'b1);
        chk(32'(logicOut), 32'h1);
        fieldSet <= 8'h00;
        repeat (150) @(posedge clk_sys);
        fieldSet <= 8'h01;
        repeat (10) @(posedge clk_sys);
        chk({24'h0, closeCnt0}, 32'h1);
        chk(32'(logicOut[0]), 32'h1);
        fieldSet <= 8'h00;
        repeat (200) @(posedge clk_sys);
        chk(32'(logicOut[0]), 32'h1);
        waitOut(0, 1'b0);
        chk(32'(logicOut[0]), 32'h0);
        fieldSet <= 8'h01;
        repeat (150) @(posedge clk_sys);
        fieldSet <= 8'h00;
        repeat (20) @(posedge clk_sys);
        fieldSet <= 8'h01;
        repeat (200) @(posedge clk_sys);
        chk(32'(logicOut[0]), 32'h0);
        waitOut(0, 1'b1);
        chk(32'(logicOut[0]), 32'h1);
        apb(1'b1, 8'h00, 32'h7);
        repeat (250) @(posedge clk_sys);
        chk(32'(logicOut), 32'h3);
        apb(1'b1, 8'h00, 32'h0);
        repeat (5) @(posedge clk_sys);
        chk(32'(logicOut), 32'h0);
    endtask : tTiming
    // ====================
    // main sequence and watchdog
    initial begin
        {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
        {fieldSet, reclSupvSet, errorCnt, cmpCount} = '0;
        repeat (20) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        tRegs();
        tEdit();
        tSupv();
        tTiming();
        testDone();
    end
    initial begin
        #1000000;
        errorCnt++;
        testDone();
    end
endmodule : testbench
`default_nettype wire
